// file: pin_function_select.sv
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none

module pin_function_select (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic low_power_mode,
   output logic wake_req,
   output logic io_supply_select,
   input wire pinmux_pkg::periph_out_t periph_out,
   output pinmux_pkg::periph_in_t periph_in,
   input wire logic [7:0] porta_in,
   output logic [7:0] porta_out,
   output logic [7:0] porta_oe_n,
   input wire logic [7:0] portb_in,
   output logic [7:0] portb_out,
   output logic [7:0] portb_oe_n,
   input wire logic [3:0] portc_in,
   output logic [3:0] portc_out,
   output logic [3:0] portc_oe_n
);

   // Extracts the two-bit field whose low bit is at pos.
   function automatic logic [1:0] field(input logic [7:0] r, input int pos);
      field = r[pos +: 2];
   endfunction : field

   // True when a field selects its alternate function.
   function automatic logic is_alt(input logic [7:0] r, input int pos);
      is_alt = (r[pos +: 2] == pinmux_pkg::CODE_ALT);
   endfunction : is_alt

   // Selection, port and wake registers.
   logic [7:0] supply_select_reg;
   logic [7:0] porta_low_sel;
   logic [7:0] porta_high_sel;
   logic [7:0] portb_low_sel;
   logic [7:0] portb_high_sel;
   logic [7:0] portc_sel;
   logic [7:0] porta_data;
   logic [7:0] porta_dir;
   logic [7:0] portb_data;
   logic [7:0] portb_dir;
   logic [3:0] portc_data;
   logic [3:0] portc_dir;
   logic [7:0] porta_wake_enable;
   logic [7:0] porta_prev;

   // Address decode strobes.
   wire logic wr_supply = reg_wr && (reg_addr == pinmux_pkg::OFF_SUPPLY_SEL);
   wire logic wr_pals = reg_wr && (reg_addr == pinmux_pkg::OFF_PORTA_LOW_SEL);
   wire logic wr_pahs = reg_wr && (reg_addr == pinmux_pkg::OFF_PORTA_HIGH_SEL);
   wire logic wr_pbls = reg_wr && (reg_addr == pinmux_pkg::OFF_PORTB_LOW_SEL);
   wire logic wr_pbhs = reg_wr && (reg_addr == pinmux_pkg::OFF_PORTB_HIGH_SEL);
   wire logic wr_pcs = reg_wr && (reg_addr == pinmux_pkg::OFF_PORTC_SEL);
   wire logic wr_wake = reg_wr && (reg_addr == pinmux_pkg::OFF_PORTA_WAKE);
   wire logic wr_bitop = reg_wr && (reg_addr == pinmux_pkg::OFF_BIT_OP);

   // Bit-operation command: target register, bit index and set or clear.
   wire logic [3:0] bitop_off = reg_wdata[pinmux_pkg::POS_BITOP_OFF +: 4];
   wire logic [2:0] bitop_bit = reg_wdata[2:0];
   wire logic bitop_set = reg_wdata[pinmux_pkg::POS_BITOP_SET];

   // Byte read of any port register, as seen by the read-modify-write path.
   logic [7:0] port_byte;
   always_comb begin
      if (bitop_off == pinmux_pkg::OFF_PORTA_DATA) begin
         port_byte = porta_data;
      end else if (bitop_off == pinmux_pkg::OFF_PORTA_DIR) begin
         port_byte = porta_dir;
      end else if (bitop_off == pinmux_pkg::OFF_PORTB_DATA) begin
         port_byte = portb_data;
      end else if (bitop_off == pinmux_pkg::OFF_PORTB_DIR) begin
         port_byte = portb_dir;
      end else if (bitop_off == pinmux_pkg::OFF_PORTC_DATA) begin
         port_byte = {4'h0, portc_data};
      end else if (bitop_off == pinmux_pkg::OFF_PORTC_DIR) begin
         port_byte = {4'h0, portc_dir};
      end else begin
         port_byte = 8'h00;
      end
   end

   // Modified byte: whole byte read, one bit changed, written back.
   logic [7:0] rmw_byte;
   always_comb begin
      rmw_byte = port_byte;
      rmw_byte[bitop_bit] = bitop_set;
   end

   // Write data for each port register: byte write or bit operation.
   wire logic [7:0] port_wdata = wr_bitop ? rmw_byte : reg_wdata;
   wire logic [3:0] port_target = wr_bitop ? bitop_off : reg_addr;
   wire logic port_wr = reg_wr && (wr_bitop || (reg_addr >= pinmux_pkg::OFF_PORTA_DATA &&
                                                reg_addr <= pinmux_pkg::OFF_PORTC_DIR));
   wire logic next_en_pad = port_wr && (port_target == pinmux_pkg::OFF_PORTA_DATA);
   wire logic next_en_pac = port_wr && (port_target == pinmux_pkg::OFF_PORTA_DIR);
   wire logic next_en_pbd = port_wr && (port_target == pinmux_pkg::OFF_PORTB_DATA);
   wire logic next_en_pbc = port_wr && (port_target == pinmux_pkg::OFF_PORTB_DIR);
   wire logic next_en_pcd = port_wr && (port_target == pinmux_pkg::OFF_PORTC_DATA);
   wire logic next_en_pcc = port_wr && (port_target == pinmux_pkg::OFF_PORTC_DIR);

   // Selection registers keep only implemented bits, so the rest read zero.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         supply_select_reg <= pinmux_pkg::RST_SEL;
         porta_low_sel <= pinmux_pkg::RST_SEL;
         porta_high_sel <= pinmux_pkg::RST_SEL;
         portb_low_sel <= pinmux_pkg::RST_SEL;
         portb_high_sel <= pinmux_pkg::RST_SEL;
         portc_sel <= pinmux_pkg::RST_SEL;
         porta_wake_enable <= pinmux_pkg::RST_WAKE;
      end else begin
         if (wr_supply) supply_select_reg <= reg_wdata & pinmux_pkg::MASK_SUPPLY_SEL;
         if (wr_pals) porta_low_sel <= reg_wdata & pinmux_pkg::MASK_LOW_SEL;
         if (wr_pahs) porta_high_sel <= reg_wdata & pinmux_pkg::MASK_FULL;
         if (wr_pbls) portb_low_sel <= reg_wdata & pinmux_pkg::MASK_LOW_SEL;
         if (wr_pbhs) portb_high_sel <= reg_wdata & pinmux_pkg::MASK_PORTB_HIGH_SEL;
         if (wr_pcs) portc_sel <= reg_wdata & pinmux_pkg::MASK_FULL;
         if (wr_wake) porta_wake_enable <= reg_wdata;
      end
   end

   // Port data and direction registers; reset leaves every pin an input, latch high.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         porta_data <= pinmux_pkg::RST_PORT;
         porta_dir <= pinmux_pkg::RST_PORT;
         portb_data <= pinmux_pkg::RST_PORT;
         portb_dir <= pinmux_pkg::RST_PORT;
         portc_data <= pinmux_pkg::RST_PORT[3:0];
         portc_dir <= pinmux_pkg::RST_PORT[3:0];
      end else begin
         if (next_en_pad) porta_data <= port_wdata;
         if (next_en_pac) porta_dir <= port_wdata;
         if (next_en_pbd) portb_data <= port_wdata;
         if (next_en_pbc) portb_dir <= port_wdata;
         if (next_en_pcd) portc_data <= port_wdata[3:0];
         if (next_en_pcc) portc_dir <= port_wdata[3:0];
      end
   end

   // Alternate-function selects for every shared pin.
   wire logic a3_timer = (field(porta_low_sel, pinmux_pkg::POS_A3) == pinmux_pkg::CODE_A3_TIMER);
   wire logic a3_supply = is_alt(porta_low_sel, pinmux_pkg::POS_A3);
   wire logic a1_alt = is_alt(porta_low_sel, pinmux_pkg::POS_A1);
   wire logic b3_alt = is_alt(portb_low_sel, pinmux_pkg::POS_B3);
   wire logic b1_alt = is_alt(portb_low_sel, pinmux_pkg::POS_B1);
   wire logic b5_alt = is_alt(portb_high_sel, pinmux_pkg::POS_B5);
   wire logic b4_alt = is_alt(portb_high_sel, pinmux_pkg::POS_B4);
   logic [3:0] a_hi_alt;
   logic [3:0] c_alt;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         a_hi_alt[i] = is_alt(porta_high_sel, 2 * i);
         c_alt[i] = is_alt(portc_sel, 2 * i);
      end
   end

   // Per-pin alternate select, drive and enable vectors for port A.
   wire logic [7:0] pa_sel = {a_hi_alt[3], a_hi_alt[2], a_hi_alt[1], a_hi_alt[0],
                              a3_timer | a3_supply, 1'b0, a1_alt, 1'b0};
   wire logic [7:0] pa_alt_out = {periph_out.aux_serial_clock_out, periph_out.aux_serial_dout,
                                  1'b1, periph_out.aux_serial_select_out,
                                  periph_out.std_timer_out, 1'b1, periph_out.compact_timer1_out, 1'b1};
   // Inputs (aux din, supply) are never driven; a3 drives only for the timer.
   wire logic [7:0] pa_alt_oe_n = {periph_out.aux_serial_clock_oe_n, 1'b0, 1'b1,
                                   periph_out.aux_serial_select_oe_n,
                                   ~a3_timer, 1'b1, 1'b0, 1'b1};

   // Per-pin vectors for port B.
   wire logic [7:0] pb_sel = {2'b00, b5_alt, b4_alt, b3_alt, 1'b0, b1_alt, 1'b0};
   wire logic [7:0] pb_alt_out = {2'b11, periph_out.compact_timer1_out_inv, periph_out.compact_timer0_out_inv,
                                  periph_out.compact_timer0_out, 1'b1, periph_out.std_timer_out_inv, 1'b1};
   wire logic [7:0] pb_alt_oe_n = {2'b11, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

   // Per-pin vectors for port C: 3 clock, 2 dout, 1 din, 0 select.
   wire logic [3:0] pc_alt_out = {periph_out.serial_clock_out, periph_out.serial_dout,
                                  periph_out.serial_din_out, periph_out.serial_module_select_out};
   wire logic [3:0] pc_alt_oe_n = {periph_out.serial_clock_oe_n, periph_out.serial_dout_oe_n,
                                   periph_out.serial_din_oe_n, periph_out.serial_module_select_oe_n};

   // Pin routing instances, one per port bit.
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pa
         pin_route u_pa (
            .alt_sel(pa_sel[g]),
            .port_data(porta_data[g]),
            .port_dir(porta_dir[g]),
            .alt_out(pa_alt_out[g]),
            .alt_oe_n(pa_alt_oe_n[g]),
            .pin_out(porta_out[g]),
            .pin_oe_n(porta_oe_n[g])
         );
         pin_route u_pb (
            .alt_sel(pb_sel[g]),
            .port_data(portb_data[g]),
            .port_dir(portb_dir[g]),
            .alt_out(pb_alt_out[g]),
            .alt_oe_n(pb_alt_oe_n[g]),
            .pin_out(portb_out[g]),
            .pin_oe_n(portb_oe_n[g])
         );
      end
      for (g = 0; g < 4; g++) begin : g_pc
         pin_route u_pc (
            .alt_sel(c_alt[g]),
            .port_data(portc_data[g]),
            .port_dir(portc_dir[g]),
            .alt_out(pc_alt_out[g]),
            .alt_oe_n(pc_alt_oe_n[g]),
            .pin_out(portc_out[g]),
            .pin_oe_n(portc_oe_n[g])
         );
      end
   endgenerate

   // Pin levels handed to peripherals; interrupts share the plain-I/O code.
   assign periph_in.aux_serial_clock_in = porta_in[7];
   assign periph_in.aux_serial_din = a_hi_alt[1] ? porta_in[5] : 1'b0;
   assign periph_in.aux_serial_select_in = a_hi_alt[0] ? porta_in[4] : 1'b1;
   assign periph_in.ext_irq_one = b5_alt ? 1'b0 : portb_in[5];
   assign periph_in.ext_irq_zero = b4_alt ? 1'b0 : portb_in[4];
   assign periph_in.serial_clock_in = c_alt[3] ? portc_in[3] : 1'b0;
   assign periph_in.serial_din_in = c_alt[1] ? portc_in[1] : 1'b1;
   assign periph_in.serial_module_select_in = c_alt[0] ? portc_in[0] : 1'b1;
   assign periph_in.io_supply_input_sel = a3_supply;

   // Port C supply: the upper field bit alone chooses the I/O supply.
   assign io_supply_select = supply_select_reg[pinmux_pkg::POS_SUPPLY_HI];

   // Port A wake: falling edge on an enabled plain-I/O pin while asleep.
   wire logic [7:0] wake_qual = porta_wake_enable & ~pa_sel;
   wire logic [7:0] fall = porta_prev & ~porta_in;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         porta_prev <= 8'hff;
         wake_req <= 1'b0;
      end else begin
         porta_prev <= porta_in;
         wake_req <= low_power_mode && |(fall & wake_qual);
      end
   end

   // Read mux; unmapped offsets and unimplemented bits read zero.
   logic [7:0] next_rdata;
   always_comb begin
      if (reg_addr == pinmux_pkg::OFF_SUPPLY_SEL) begin
         next_rdata = supply_select_reg;
      end else if (reg_addr == pinmux_pkg::OFF_PORTA_LOW_SEL) begin
         next_rdata = porta_low_sel;
      end else if (reg_addr == pinmux_pkg::OFF_PORTA_HIGH_SEL) begin
         next_rdata = porta_high_sel;
      end else if (reg_addr == pinmux_pkg::OFF_PORTB_LOW_SEL) begin
         next_rdata = portb_low_sel;
      end else if (reg_addr == pinmux_pkg::OFF_PORTB_HIGH_SEL) begin
         next_rdata = portb_high_sel;
      end else if (reg_addr == pinmux_pkg::OFF_PORTC_SEL) begin
         next_rdata = portc_sel;
      end else if (reg_addr == pinmux_pkg::OFF_PORTA_DATA) begin
         next_rdata = porta_data;
      end else if (reg_addr == pinmux_pkg::OFF_PORTA_DIR) begin
         next_rdata = porta_dir;
      end else if (reg_addr == pinmux_pkg::OFF_PORTB_DATA) begin
         next_rdata = portb_data;
      end else if (reg_addr == pinmux_pkg::OFF_PORTB_DIR) begin
         next_rdata = portb_dir;
      end else if (reg_addr == pinmux_pkg::OFF_PORTC_DATA) begin
         next_rdata = {4'h0, portc_data};
      end else if (reg_addr == pinmux_pkg::OFF_PORTC_DIR) begin
         next_rdata = {4'h0, portc_dir};
      end else if (reg_addr == pinmux_pkg::OFF_PORTA_WAKE) begin
         next_rdata = porta_wake_enable;
      end else begin
         next_rdata = 8'h00;
      end
   end

   // Read data stands one cycle after the read strobe only.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : 8'h00;
      end
   end

   // Assertions.
   chk_supply_unimpl_zero: assert property (@(posedge mclk) disable iff (!nrst)
      (supply_select_reg & ~pinmux_pkg::MASK_SUPPLY_SEL) == 8'h00)
      else $error("supply select holds unimplemented bits");
   chk_read_zero_bits: assert property (@(posedge mclk) disable iff (!nrst)
      reg_rd && reg_addr == pinmux_pkg::OFF_PORTB_HIGH_SEL |=> reg_rdata[7:4] == 4'h0)
      else $error("unimplemented select bits read nonzero");
   chk_supply_follows: assert property (@(posedge mclk) disable iff (!nrst)
      wr_supply |=> io_supply_select == $past(reg_wdata[1]))
      else $error("supply select did not follow write");
   chk_a1_timer: assert property (@(posedge mclk) disable iff (!nrst)
      wr_pals && reg_wdata[3:2] == 2'h3 |=> porta_out[1] == periph_out.compact_timer1_out && !porta_oe_n[1])
      else $error("pin a1 not routed to compact timer 1");
   chk_b1_inv_timer: assert property (@(posedge mclk) disable iff (!nrst)
      b1_alt |-> portb_out[1] == periph_out.std_timer_out_inv)
      else $error("pin b1 not routed to inverted timer");
   chk_c3_serial: assert property (@(posedge mclk) disable iff (!nrst)
      wr_pcs && reg_wdata[7:6] != 2'h3 |=> portc_out[3] == portc_data[3] && portc_oe_n[3] == portc_dir[3])
      else $error("pin c3 left plain I/O incorrectly");
   chk_a3_supply_hiz: assert property (@(posedge mclk) disable iff (!nrst)
      a3_supply |-> porta_oe_n[3])
      else $error("pin a3 driven while it is supply input");
   chk_rmw_bit: assert property (@(posedge mclk) disable iff (!nrst)
      wr_bitop && bitop_off == pinmux_pkg::OFF_PORTA_DIR |=>
      porta_dir[$past(bitop_bit)] == $past(bitop_set) &&
      ((porta_dir ^ $past(porta_dir)) & ~(8'h01 << $past(bitop_bit))) == 8'h00)
      else $error("bit operation disturbed other bits");
   chk_wake_gate: assert property (@(posedge mclk) disable iff (!nrst)
      !low_power_mode |=> !wake_req)
      else $error("wake raised outside low power mode");
   chk_reset_input: assert property (@(posedge mclk)
      $rose(nrst) |-> porta_oe_n == 8'hff && portb_oe_n == 8'hff)
      else $error("pins not inputs after reset");

endmodule : pin_function_select

`default_nettype wire

// file: pinmux_pkg.sv
package pinmux_pkg;

   // Register offsets on the plain register port (chosen map).
   localparam logic [3:0] OFF_SUPPLY_SEL = 4'h0;
   localparam logic [3:0] OFF_PORTA_LOW_SEL = 4'h1;
   localparam logic [3:0] OFF_PORTA_HIGH_SEL = 4'h2;
   localparam logic [3:0] OFF_PORTB_LOW_SEL = 4'h3;
   localparam logic [3:0] OFF_PORTB_HIGH_SEL = 4'h4;
   localparam logic [3:0] OFF_PORTC_SEL = 4'h5;
   localparam logic [3:0] OFF_PORTA_DATA = 4'h6;
   localparam logic [3:0] OFF_PORTA_DIR = 4'h7;
   localparam logic [3:0] OFF_PORTB_DATA = 4'h8;
   localparam logic [3:0] OFF_PORTB_DIR = 4'h9;
   localparam logic [3:0] OFF_PORTC_DATA = 4'ha;
   localparam logic [3:0] OFF_PORTC_DIR = 4'hb;
   localparam logic [3:0] OFF_PORTA_WAKE = 4'hc;
   localparam logic [3:0] OFF_BIT_OP = 4'hd;

   // Implemented-bit masks of the selection registers.
   localparam logic [7:0] MASK_SUPPLY_SEL = 8'h03;
   localparam logic [7:0] MASK_LOW_SEL = 8'hcc;
   localparam logic [7:0] MASK_PORTB_HIGH_SEL = 8'h0f;
   localparam logic [7:0] MASK_FULL = 8'hff;
   localparam logic [7:0] MASK_PORTC = 8'h0f;

   // Values after reset.
   localparam logic [7:0] RST_SEL = 8'h00;
   localparam logic [7:0] RST_PORT = 8'hff;
   localparam logic [7:0] RST_WAKE = 8'h00;

   // Field positions of the selection registers (low bit of each field, upper bit of the supply field).
   localparam int POS_A3 = 6;
   localparam int POS_A1 = 2;
   localparam int POS_B3 = 6;
   localparam int POS_B1 = 2;
   localparam int POS_B5 = 2;
   localparam int POS_B4 = 0;
   localparam int POS_SUPPLY_HI = 1;

   // Bit-operation command word layout: [7] set/clear, [6:3] target offset, [2:0] bit.
   localparam int POS_BITOP_SET = 7;
   localparam int POS_BITOP_OFF = 3;

   // Field codes.
   localparam logic [1:0] CODE_ALT = 2'h3;
   localparam logic [1:0] CODE_A3_TIMER = 2'h2;

   // Peripheral signals that the mux routes.
   typedef struct packed {
      logic std_timer_out;
      logic std_timer_out_inv;
      logic compact_timer0_out;
      logic compact_timer0_out_inv;
      logic compact_timer1_out;
      logic compact_timer1_out_inv;
      logic aux_serial_clock_out;
      logic aux_serial_clock_oe_n;
      logic aux_serial_dout;
      logic aux_serial_select_out;
      logic aux_serial_select_oe_n;
      logic serial_clock_out;
      logic serial_clock_oe_n;
      logic serial_dout;
      logic serial_dout_oe_n;
      logic serial_din_out;
      logic serial_din_oe_n;
      logic serial_module_select_out;
      logic serial_module_select_oe_n;
   } periph_out_t;

   // Pin levels handed back to peripherals.
   typedef struct packed {
      logic aux_serial_clock_in;
      logic aux_serial_din;
      logic aux_serial_select_in;
      logic ext_irq_zero;
      logic ext_irq_one;
      logic serial_clock_in;
      logic serial_din_in;
      logic serial_module_select_in;
      logic io_supply_input_sel;
   } periph_in_t;

endpackage : pinmux_pkg

// file: pin_route.sv
`timescale 1ns/10ps
`default_nettype none

// One pin: chooses between the port latch/direction and a peripheral drive.
module pin_route (
   input wire logic alt_sel,
   input wire logic port_data,
   input wire logic port_dir,
   input wire logic alt_out,
   input wire logic alt_oe_n,
   output logic pin_out,
   output logic pin_oe_n
);
   // Port direction 0 drives the pin, 1 leaves it an input.
   assign pin_out = alt_sel ? alt_out : port_data;
   assign pin_oe_n = alt_sel ? alt_oe_n : port_dir;
endmodule : pin_route

`default_nettype wire

// file: pin_partner.sv
`timescale 1ns/10ps
`default_nettype none

// Far side of the selector: peripheral outputs and the external pin levels.
module pin_partner (
   input wire pinmux_pkg::periph_out_t periph_word,
   input wire logic [7:0] pa_ext,
   input wire logic [7:0] pb_ext,
   input wire logic [7:0] pa_out,
   input wire logic [7:0] pa_oe_n,
   input wire logic [7:0] pb_out,
   input wire logic [7:0] pb_oe_n,
   input wire logic [3:0] pc_out,
   input wire logic [3:0] pc_oe_n,
   output pinmux_pkg::periph_out_t periph_out,
   output logic [7:0] pa_in,
   output logic [7:0] pb_in,
   output logic [3:0] pc_in
);
   // The peripherals present whatever the bench asks of them.
   assign periph_out = periph_word;
   // A pin shows its own driver when enabled, else the outside level.
   assign pa_in = (pa_oe_n & pa_ext) | (~pa_oe_n & pa_out);
   assign pb_in = (pb_oe_n & pb_ext) | (~pb_oe_n & pb_out);
   // Port C has only pull-ups outside, so a released pin reads high.
   assign pc_in = pc_oe_n | (~pc_oe_n & pc_out);
endmodule : pin_partner

`default_nettype wire

// file: tb_pin_function_select.sv
`timescale 1ns/10ps
`default_nettype none

// Register-driven checks of pin routing, masks, bit operations and wake-up.
module tb_pin_function_select;
   logic mclk, nrst, reg_wr, reg_rd, low_power_mode, wake_req, io_sel;
   logic [3:0] reg_addr, pc_in, pc_out, pc_oe_n;
   logic [7:0] reg_wdata, reg_rdata, pa_ext, pb_ext, pa_in, pa_out, pa_oe_n, pb_in, pb_out, pb_oe_n;
   pinmux_pkg::periph_out_t po, po_w;
   pinmux_pkg::periph_in_t pi;
   // Pin levels handed back to the peripherals, packed into one byte for comparison.
   wire logic [7:0] pi_lines = {2'h0, pi.aux_serial_clock_in, pi.aux_serial_din, pi.aux_serial_select_in,
                                pi.serial_clock_in, pi.serial_din_in, pi.serial_module_select_in};
   int err_count = 0;
   int samples_checked = 0;
   logic [7:0] msk [6] = '{8'h03, 8'hcc, 8'hff, 8'hcc, 8'h0f, 8'hff};

   pin_function_select u_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .low_power_mode(low_power_mode),
      .wake_req(wake_req), .io_supply_select(io_sel), .periph_out(po_w), .periph_in(pi),
      .porta_in(pa_in), .porta_out(pa_out), .porta_oe_n(pa_oe_n), .portb_in(pb_in), .portb_out(pb_out),
      .portb_oe_n(pb_oe_n), .portc_in(pc_in), .portc_out(pc_out), .portc_oe_n(pc_oe_n));
   pin_partner u_far (.periph_word(po), .pa_ext(pa_ext), .pb_ext(pb_ext), .pa_out(pa_out),
      .pa_oe_n(pa_oe_n), .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pc_out(pc_out), .pc_oe_n(pc_oe_n),
      .periph_out(po_w), .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in));

   // Free-running system clock.
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // Compares one byte and reports a difference.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // One-cycle register write; returns once the taking edge has landed.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   // One-cycle register read; the data are looked at in the following cycle.
   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rchk

   // Watches the wake request for a few cycles after a pin change.
   task automatic wake_chk(input logic [7:0] ext, input logic exp);
      logic seen;
      seen = 1'b0;
      @(posedge mclk);
      pa_ext <= ext;
      repeat (4) begin
         @(posedge mclk);
         #1 seen = seen | (wake_req === 1'b1);
      end
      chk({7'h0, seen}, {7'h0, exp});
      pa_ext <= 8'hff;
   endtask : wake_chk

   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test

   // Cuts a hang short well beyond the expected run length.
   initial begin
      #(40 * 3000);
      err_count++;
      end_of_test();
   end

   // Main test sequence.
   initial begin
      nrst = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      low_power_mode = 1'b0;
      po = '0;
      pa_ext = 8'hff;
      pb_ext = 8'hff;
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      // Port C data and direction hold only four bits, so they read back as 0f.
      for (int a = 0; a < 13; a++) begin
         rchk(4'(a), (a >= 6 && a <= 9) ? 8'hff : ((a == 10 || a == 11) ? 8'h0f : 8'h00));
      end
      chk(pa_oe_n, 8'hff);
      wr(4'hd, 8'h3b);
      rchk(4'h7, 8'hf7);
      chk(pa_oe_n, 8'hf7);
      chk(pa_out, 8'hff);
      wr(4'hd, 8'hbb);
      rchk(4'h7, 8'hff);
      for (int a = 1; a < 7; a++) begin
         wr(4'(a % 6), 8'hff);
         rchk(4'(a % 6), msk[a % 6]);
      end
      wr(4'he, 8'hff);
      rchk(4'he, 8'h00);
      chk({7'h0, pi.io_supply_input_sel}, 8'h01);
      chk({7'h0, io_sel}, 8'h01);
      wr(4'h0, 8'h01);
      chk({7'h0, io_sel}, 8'h00);
      wr(4'h1, 8'h8c);
      chk(pa_out & 8'hda, 8'h00);
      chk(pb_out & 8'h3a, 8'h00);
      chk({4'h0, pc_out}, 8'h00);
      // With the peripherals idle, driven alternate pins carry their low levels back.
      chk(pi_lines, 8'h10);
      chk(pa_oe_n, 8'h25);
      chk(pb_oe_n, 8'hc5);
      chk({4'h0, pc_oe_n}, 8'h00);
      // Plain timer and serial outputs high, inverted outputs and enables low, so a swap shows.
      po <= 19'h556aa;
      #1;
      chk(pa_out & 8'hda, 8'hda);
      chk(pb_out & 8'h3a, 8'h08);
      chk({4'h0, pc_out}, 8'h0f);
      chk(pi_lines, 8'h3f);
      po <= '0;
      for (int a = 1; a < 6; a++) wr(4'(a), 8'haa);
      chk(pa_out & 8'hda, 8'hd2);
      chk(pb_out & 8'h3a, 8'h3a);
      chk({4'h0, pc_out}, 8'h0f);
      chk({4'h0, pc_oe_n}, 8'h0f);
      pb_ext <= 8'hcf;
      @(posedge mclk);
      #1 chk({6'h0, pi.ext_irq_one, pi.ext_irq_zero}, 8'h00);
      pb_ext <= 8'hff;
      @(posedge mclk);
      #1 chk({6'h0, pi.ext_irq_one, pi.ext_irq_zero}, 8'h03);
      wr(4'hc, 8'h11);
      wr(4'h2, 8'h03);
      po.aux_serial_select_oe_n <= 1'b1;
      wake_chk(8'hfe, 1'b0);
      low_power_mode <= 1'b1;
      wake_chk(8'hef, 1'b0);
      wake_chk(8'hfe, 1'b1);
      end_of_test();
   end
endmodule : tb_pin_function_select

`default_nettype wire
